// File: core/ioxp_device.sv
// Expander end: two-wire target, four byte registers, port pins and alert.
`include "ioxp_defs.svh"

module ioxp_device
  import ioxp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  ioxp_if.dev link,
  input wire logic addr_sel,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);
  ioxp_dev_s q;
  ioxp_dev_s next_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [6:0] own_addr;
  logic [7:0] in_byte;
  logic [7:0] tx_byte;
  logic [7:0] in_view;

  ioxp_line_sense u_sense (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .scl(link.scl),
    .sda(link.sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  // The address select pin picks one of two target addresses.
  assign own_addr = addr_sel ? `IOXP_ADDR_HI : `IOXP_ADDR_LO; // see (RULE6)

  // Live pin levels, whatever the direction, with per-bit inversion.
  assign in_view = pin_in ^ q.invert; // see (RULE10) see (RULE14)

  assign in_byte = {q.shift[6:0], link.sda};

  // The stored command picks the byte sent back on a read.
  always_comb begin
    unique case (q.ctrl[1:0]) // see (RULE9)
      `IOXP_SEL_IN: tx_byte = in_view; // see (RULE5)
      `IOXP_SEL_OUT: tx_byte = q.latch; // see (RULE13)
      `IOXP_SEL_INV: tx_byte = q.invert;
      `IOXP_SEL_DIR: tx_byte = ~q.out_en;
    endcase
  end

  always_comb begin
    next_q = q;

    // The alert baseline is taken once after reset, from the live pins.
    if (!q.snap_ok) begin
      next_q.snap = pin_in;
      next_q.snap_ok = 1'b1;
    end

    // Only pins set as inputs are compared, so outputs never raise the alert.
    next_q.alert = q.snap_ok && (((pin_in ^ q.snap) & ~q.out_en) != `IOXP_NO_CHANGE); // see (RULE18) see (RULE19)

    if (stop_seen) begin
      next_q.state = DS_IDLE; // see (RULE4)
      next_q.sda_oe = 1'b0;
      next_q.ack_on = 1'b0;
    end else if (start_seen) begin
      next_q.state = DS_ADDR;
      next_q.bit_cnt = '0;
      next_q.sda_oe = 1'b0;
      next_q.ack_on = 1'b0;
    end else if (scl_rise) begin
      unique case (q.state)
        DS_ADDR, DS_CMD, DS_WDATA: begin
          next_q.shift = in_byte;
          next_q.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == `IOXP_LAST_BIT) begin
            if (q.state == DS_CMD) begin
              next_q.ctrl = in_byte; // see (RULE8)
              next_q.state = DS_ACK_CMD;
            end else if (q.state == DS_WDATA) begin
              next_q.state = DS_ACK_DATA;
            end else if (in_byte[7:1] == own_addr) begin // see (RULE6)
              next_q.rw = in_byte[0]; // see (RULE7)
              next_q.state = DS_ACK_ADDR;
            end else begin
              next_q.state = DS_IGNORE; // see (RULE20)
            end
          end
        end
        DS_RACK: begin
          // Reading the input register re-bases the alert at this acknowledge.
          if (q.ctrl[1:0] == `IOXP_SEL_IN) begin
            next_q.snap = pin_in; // see (RULE19)
          end
          if (link.sda) begin
            next_q.state = DS_IGNORE; // see (RULE3)
          end else begin
            next_q.ack_on = 1'b1; // see (RULE3)
          end
        end
        DS_IDLE, DS_ACK_ADDR, DS_ACK_CMD, DS_ACK_DATA, DS_RDATA, DS_IGNORE: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (q.state)
        DS_ACK_ADDR, DS_ACK_CMD, DS_ACK_DATA: begin
          if (!q.ack_on) begin
            next_q.sda_oe = 1'b1;
            next_q.ack_on = 1'b1;
            // A data byte takes effect as its acknowledge begins.
            if (q.state == DS_ACK_DATA) begin
              unique case (q.ctrl[1:0]) // see (RULE9) see (RULE4)
                `IOXP_SEL_IN: begin
                end // see (RULE11)
                `IOXP_SEL_OUT: next_q.latch = q.shift; // see (RULE12)
                `IOXP_SEL_INV: next_q.invert = q.shift; // see (RULE14)
                `IOXP_SEL_DIR: next_q.out_en = ~q.shift; // see (RULE15)
              endcase
            end
          end else begin
            next_q.ack_on = 1'b0;
            next_q.sda_oe = 1'b0;
            next_q.bit_cnt = '0;
            if (q.state == DS_ACK_ADDR && q.rw == `IOXP_RW_READ) begin
              // Reads need no command byte: the stored command is reused.
              next_q.shift = tx_byte; // see (RULE2) see (RULE5)
              next_q.sda_oe = ~tx_byte[7];
              next_q.state = DS_RDATA;
            end else if (q.state == DS_ACK_ADDR) begin
              next_q.state = DS_CMD; // see (RULE16)
            end else begin
              next_q.state = DS_WDATA; // see (RULE16)
            end
          end
        end
        DS_RDATA: begin
          if (q.bit_cnt == `IOXP_LAST_BIT) begin
            next_q.sda_oe = 1'b0;
            next_q.state = DS_RACK;
          end else begin
            next_q.bit_cnt = q.bit_cnt + 3'h1;
            next_q.shift = {q.shift[6:0], 1'b0};
            next_q.sda_oe = ~q.shift[6]; // see (RULE2)
          end
        end
        DS_RACK: begin
          if (q.ack_on) begin
            next_q.ack_on = 1'b0;
            next_q.bit_cnt = '0;
            next_q.shift = tx_byte; // see (RULE2)
            next_q.sda_oe = ~tx_byte[7];
            next_q.state = DS_RDATA;
          end
        end
        DS_IDLE, DS_ADDR, DS_CMD, DS_WDATA, DS_IGNORE: begin
        end
      endcase
    end
  end

  // Reset forces the registers and the bus state machine to defaults.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q.state <= DS_IDLE; // see (RULE17)
      q.ack_on <= 1'b0;
      q.bit_cnt <= '0;
      q.shift <= `IOXP_NO_CHANGE;
      q.rw <= `IOXP_RW_WRITE;
      q.ctrl <= `IOXP_CTRL_RST;
      q.latch <= `IOXP_OUT_RST;
      q.invert <= `IOXP_INV_RST;
      q.out_en <= ~`IOXP_DIR_RST;
      q.snap <= `IOXP_NO_CHANGE;
      q.snap_ok <= 1'b0;
      q.alert <= 1'b0;
      q.sda_oe <= 1'b0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign pin_out = q.latch; // see (RULE12)
  assign pin_oe = q.out_en; // see (RULE15)
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.sda_oe;
  assign link.dev_alert_o = 1'b0;
  assign link.dev_alert_oe = q.alert; // see (RULE18)
endmodule : ioxp_device

// File: core/ioxp_defs.svh
// Constants shared by both ends of the 8-bit I/O expander link.
// Operation
// (RULE1) Register read: write index, repeated start, readdress.
// (RULE2) Device drives read bytes while controller clocks.
// (RULE3) Controller acks for more, nacks last, stops.
// (RULE4) Stop ends transfer; last acknowledged data stands.
// (RULE5) Input index kept allows reads without command.
// (RULE6) Address 20h with select low, 21h high.
// (RULE7) Address byte low bit: one reads, zero writes.
// (RULE8) Write carries command byte, stored in control.
// (RULE9) Two low command bits pick the register.
// (RULE10) Input register returns pin levels in any direction.
// (RULE11) Writes to the input register change nothing.
// (RULE12) Output latch drives only pins set as outputs.
// (RULE13) Output latch reads return flip-flops, not pins.
// (RULE14) Invert bit one reports input pin inverted.
// (RULE15) Direction one is input, zero drives output.
// (RULE16) Register write: address, index, data, then stop.
// (RULE17) Reset pin low forces registers and bus idle.
// (RULE18) Input pin change asserts alert; outputs never.
// (RULE19) Alert clears on return or at read acknowledge.
// (RULE20) Foreign address gets no acknowledge, line released.
`ifndef IOXP_DEFS_SVH
`define IOXP_DEFS_SVH

`define IOXP_ADDR_LO 7'h20
`define IOXP_ADDR_HI 7'h21
`define IOXP_RW_READ 1'b1
`define IOXP_RW_WRITE 1'b0

`define IOXP_SEL_IN 2'h0
`define IOXP_SEL_OUT 2'h1
`define IOXP_SEL_INV 2'h2
`define IOXP_SEL_DIR 2'h3

`define IOXP_OUT_RST 8'hff
`define IOXP_INV_RST 8'h00
`define IOXP_DIR_RST 8'hff
`define IOXP_CTRL_RST 8'h00
`define IOXP_LINE_IDLE 1'b1
`define IOXP_IDLE_BYTE 8'hff
`define IOXP_NO_CHANGE 8'h00

`define IOXP_LAST_BIT 3'h7
`define IOXP_ACK_SLOT 4'h8
`define IOXP_Q_FIRST 2'h0
`define IOXP_Q_RISE 2'h1
`define IOXP_Q_SAMPLE 2'h2
`define IOXP_Q_LAST 2'h3

`define IOXP_CLK_PERIOD_NS 5
`define IOXP_SCL_PERIOD_NS 2500
`define IOXP_QTR_CYC \
  ((`IOXP_SCL_PERIOD_NS + 4 * `IOXP_CLK_PERIOD_NS - 1) / (4 * `IOXP_CLK_PERIOD_NS))
`define IOXP_TMR_W 8

`endif

// File: core/ioxp_pkg.sv
// Types shared by both ends of the I/O expander link.
`include "ioxp_defs.svh"

package ioxp_pkg;

  typedef enum logic [3:0] {
    DS_IDLE, DS_ADDR, DS_ACK_ADDR, DS_CMD, DS_ACK_CMD, DS_WDATA, DS_ACK_DATA,
    DS_RDATA, DS_RACK, DS_IGNORE
  } ioxp_dev_state_e;

  typedef enum logic [1:0] {HO_IDLE, HO_START, HO_BYTE, HO_STOP} ioxp_host_op_e;

  typedef enum logic [2:0] {HS_ADDRW, HS_REG, HS_DATA, HS_ADDRR, HS_RX} ioxp_host_step_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } ioxp_line_s;

  typedef struct packed {
    ioxp_dev_state_e state;
    logic ack_on;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ctrl;
    logic [7:0] latch;
    logic [7:0] invert;
    logic [7:0] out_en;
    logic [7:0] snap;
    logic snap_ok;
    logic alert;
    logic sda_oe;
  } ioxp_dev_s;

  typedef struct packed {
    ioxp_host_op_e op;
    ioxp_host_step_e step;
    logic [1:0] quarter;
    logic [`IOXP_TMR_W-1:0] timer;
    logic [3:0] bit_idx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic ack_bit;
    logic rw;
    logic short_rd;
    logic [6:0] addr;
    logic [7:0] reg_idx;
    logic [7:0] wdata;
    logic scl_oe;
    logic sda_oe;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic rsp_nack;
  } ioxp_host_s;

endpackage : ioxp_pkg

// File: core/ioxp_if.sv
// Open-drain two-wire link and alert line joining controller and expander.
interface ioxp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_alert_o;
  logic dev_alert_oe;
  logic scl;
  logic sda;
  logic alert_n;

  // Wired-AND: a line is low while any driver enables a low output.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  assign alert_n = !(dev_alert_oe && !dev_alert_o);

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );

  modport dev (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe,
    output dev_alert_o,
    output dev_alert_oe
  );
endinterface : ioxp_if

// File: core/ioxp_line_sense.sv
// Edge and start/stop detection on the two-wire link.
`include "ioxp_defs.svh"

module ioxp_line_sense
  import ioxp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  ioxp_line_s q;
  ioxp_line_s next_q;

  always_comb begin
    next_q.scl = scl;
    next_q.sda = sda;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q.scl <= `IOXP_LINE_IDLE;
      q.sda <= `IOXP_LINE_IDLE;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign scl_rise = clk_en & scl & ~q.scl;
  assign scl_fall = clk_en & ~scl & q.scl;
  assign start_seen = clk_en & q.scl & scl & q.sda & ~sda;
  assign stop_seen = clk_en & q.scl & scl & ~q.sda & sda;
endmodule : ioxp_line_sense

// File: core/ioxp_host.sv
// Controller end: issues single-byte register writes and reads on the link.
`include "ioxp_defs.svh"

module ioxp_host
  import ioxp_pkg::*;
#(
  parameter logic [`IOXP_TMR_W-1:0] QTR_CYC = `IOXP_TMR_W'(`IOXP_QTR_CYC)
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  ioxp_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_rw,
  input wire logic cmd_short,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  ioxp_host_s q;
  ioxp_host_s next_q;

  always_comb begin
    next_q = q;
    next_q.rsp_valid = 1'b0;
    if (q.op == HO_IDLE) begin
      if (cmd_valid && q.cmd_ready) begin
        next_q.cmd_ready = 1'b0;
        next_q.rw = cmd_rw;
        next_q.short_rd = cmd_short;
        next_q.addr = cmd_addr;
        next_q.reg_idx = cmd_reg;
        next_q.wdata = cmd_wdata;
        next_q.op = HO_START;
        next_q.quarter = '0;
        next_q.timer = QTR_CYC;
        next_q.step = (cmd_rw && cmd_short) ? HS_ADDRR : HS_ADDRW; // see (RULE5)
      end
    end else if (q.timer != '0) begin
      next_q.timer = q.timer - `IOXP_TMR_W'(1);
    end else begin
      next_q.timer = QTR_CYC;
      next_q.quarter = q.quarter + 2'h1;
      unique case (q.op)
        HO_START: begin
          next_q.sda_oe = (q.quarter >= `IOXP_Q_SAMPLE);
          // A start from idle keeps the clock high in its first quarter.
          next_q.scl_oe = (q.quarter == `IOXP_Q_LAST) ||
                          ((q.quarter == `IOXP_Q_FIRST) && q.scl_oe);
          if (q.quarter == `IOXP_Q_LAST) begin
            next_q.op = HO_BYTE;
            next_q.bit_idx = '0;
            next_q.tx = (q.step == HS_ADDRR) ? {q.addr, `IOXP_RW_READ} // see (RULE1) see (RULE7)
                                             : {q.addr, `IOXP_RW_WRITE}; // see (RULE7)
          end
        end
        HO_BYTE: begin
          unique case (q.quarter)
            `IOXP_Q_FIRST: begin
              next_q.sda_oe = (q.bit_idx != `IOXP_ACK_SLOT) && !q.tx[7]; // see (RULE3)
            end
            `IOXP_Q_RISE: next_q.scl_oe = 1'b0;
            `IOXP_Q_SAMPLE: begin
              if (q.bit_idx == `IOXP_ACK_SLOT) begin
                next_q.ack_bit = link.sda;
              end else begin
                next_q.rx = {q.rx[6:0], link.sda};
                next_q.tx = {q.tx[6:0], 1'b1};
              end
            end
            `IOXP_Q_LAST: begin
              next_q.scl_oe = 1'b1;
              next_q.bit_idx = q.bit_idx + 4'h1;
              if (q.bit_idx == `IOXP_ACK_SLOT) begin
                next_q.bit_idx = '0;
                if (q.ack_bit && q.step != HS_RX) begin
                  next_q.rsp_nack = 1'b1;
                  next_q.op = HO_STOP;
                end else begin
                  unique case (q.step)
                    HS_ADDRW: begin
                      next_q.step = HS_REG; // see (RULE8) see (RULE16)
                      next_q.tx = q.reg_idx;
                    end
                    HS_REG: begin
                      if (q.rw) begin
                        next_q.step = HS_ADDRR; // see (RULE1)
                        next_q.op = HO_START;
                      end else begin
                        next_q.step = HS_DATA; // see (RULE16)
                        next_q.tx = q.wdata;
                      end
                    end
                    HS_ADDRR: begin
                      next_q.step = HS_RX;
                      next_q.tx = `IOXP_IDLE_BYTE;
                    end
                    HS_DATA, HS_RX: next_q.op = HO_STOP; // see (RULE3) see (RULE16)
                  endcase
                end
              end
            end
          endcase
        end
        HO_STOP: begin
          next_q.sda_oe = (q.quarter != `IOXP_Q_SAMPLE) && (q.quarter != `IOXP_Q_LAST);
          next_q.scl_oe = (q.quarter == `IOXP_Q_FIRST);
          if (q.quarter == `IOXP_Q_LAST) begin
            next_q.op = HO_IDLE;
            next_q.cmd_ready = 1'b1;
            next_q.rsp_valid = 1'b1;
            next_q.rsp_rdata = q.rx;
          end
        end
        HO_IDLE: begin
        end
      endcase
    end
    if (q.op == HO_IDLE && cmd_valid && q.cmd_ready) begin
      next_q.rsp_nack = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.op <= HO_IDLE;
      q.step <= HS_ADDRW;
      q.cmd_ready <= 1'b1;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = q.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_oe;
  assign cmd_ready = q.cmd_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rsp_rdata;
  assign rsp_nack = q.rsp_nack;
endmodule : ioxp_host

// File: verif/ioxp_assertions.sv
// Concurrent checks on the two-wire link between controller and expander.
module ioxp_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_alert_o,
  input wire logic dev_alert_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q;
  logic sda_q;
  logic in_frame;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Tracks whether the link is between a start and a stop.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        in_frame <= 1'b1;
      end else if (scl && scl_q && !sda_q && sda) begin
        in_frame <= 1'b0;
      end
    end
  end

  a_rst_release_quiet: assert property (
    $rose(nrst) |-> !dev_sda_oe && !dev_alert_oe && !host_scl_oe && !host_sda_oe)
    else $error("link driver active at reset release");
  a_alert_wait_base: assert property (
    $rose(nrst) |=> !dev_alert_oe)
    else $error("alert raised before baseline taken");
  a_dev_sda_lowclk: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_open_drain_low: assert property (
    !dev_sda_o && !host_sda_o && !host_scl_o && !dev_alert_o)
    else $error("open-drain output drives high");
  a_dev_in_frame: assert property (
    !in_frame |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  a_scl_in_frame: assert property (
    $fell(scl) |-> in_frame)
    else $error("clock pulse outside a frame");
  a_scl_high_hold: assert property (
    $rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_hold: assert property (
    $fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
endmodule : ioxp_assertions

// File: verif/testbench.sv
// Self-checking bench joining the controller and expander ends.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic stall_on = 1'b0;
  logic addr_sel = 1'b0;
  logic [7:0] ext = 8'h00;
  logic cmd_valid = 1'b0;
  logic cmd_rw = 1'b0;
  logic cmd_short = 1'b0;
  logic [6:0] cmd_addr = 7'h20;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic nk;
  logic [7:0] rsp_rdata, pin_in, pin_out, pin_oe, rd;
  logic [7:0] m_out, m_inv, m_dir, m_ctrl;
  int err_count = 0;
  int n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  // Random clock-enable gaps stretch both ends alike while the stall window is open.
  always @(posedge core_clk) begin
    #1;
    clk_en = !stall_on || ($urandom_range(3) != 0);
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  ioxp_if i_ioxp_if ();
  ioxp_host #(.QTR_CYC(8'h04)) i_ioxp_host (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .link(i_ioxp_if.host), .cmd_valid(cmd_valid), .cmd_rw(cmd_rw), .cmd_short(cmd_short),
    .cmd_addr(cmd_addr), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  ioxp_device i_ioxp_device (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .link(i_ioxp_if.dev), .addr_sel(addr_sel), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  ioxp_assertions i_ioxp_assertions (.core_clk(core_clk), .nrst(nrst),
    .host_scl_o(i_ioxp_if.host_scl_o), .host_scl_oe(i_ioxp_if.host_scl_oe),
    .host_sda_o(i_ioxp_if.host_sda_o), .host_sda_oe(i_ioxp_if.host_sda_oe),
    .dev_sda_o(i_ioxp_if.dev_sda_o), .dev_sda_oe(i_ioxp_if.dev_sda_oe),
    .dev_alert_o(i_ioxp_if.dev_alert_o), .dev_alert_oe(i_ioxp_if.dev_alert_oe),
    .scl(i_ioxp_if.scl), .sda(i_ioxp_if.sda));

  function automatic logic [7:0] exp_reg(input logic [1:0] sel);
    case (sel)
      2'h0: exp_reg = ((~m_dir & m_out) | (m_dir & ext)) ^ m_inv;
      2'h1: exp_reg = m_out;
      2'h2: exp_reg = m_inv;
      default: exp_reg = m_dir;
    endcase
  endfunction : exp_reg

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset;
    nrst = 1'b0;
    m_out = 8'hff;
    m_inv = 8'h00;
    m_dir = 8'hff;
    m_ctrl = 8'h00;
    repeat (5) @(posedge core_clk);
    #1;
    nrst = 1'b1;
  endtask : do_reset

  task automatic xfer(input logic rw, input logic sh, input logic [6:0] a, input logic [7:0] r,
                      input logic [7:0] w);
    int n;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_rw = rw;
    cmd_short = sh;
    cmd_addr = a;
    cmd_reg = r;
    cmd_wdata = w;
    chk1("cmd_ready idle", 1'b1, cmd_ready);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (cmd_ready !== 1'b0 && n < 50);
    chk1("cmd_ready busy", 1'b0, cmd_ready);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 5000);
    chk1("rsp_valid", 1'b1, rsp_valid);
    rd = rsp_rdata;
    nk = rsp_nack;
  endtask : xfer

  task automatic wr(input logic [7:0] r, input logic [7:0] w);
    xfer(1'b0, 1'b0, {6'h10, addr_sel}, r, w);
    chk1("write nack", 1'b0, nk);
    case (r[1:0])
      2'h1: m_out = w;
      2'h2: m_inv = w;
      2'h3: m_dir = w;
      default: ;
    endcase
    m_ctrl = r;
  endtask : wr

  task automatic rdchk(input logic sh, input logic [7:0] r);
    xfer(1'b1, sh, {6'h10, addr_sel}, r, 8'h00);
    if (!sh) begin
      m_ctrl = r;
    end
    chk1("read nack", 1'b0, nk);
    chk8("read data", exp_reg(m_ctrl[1:0]), rd);
  endtask : rdchk

  task automatic chk_pins;
    chk8("pin_out", m_out, pin_out);
    chk8("pin_oe", ~m_dir, pin_oe);
  endtask : chk_pins

  task automatic chk_defaults;
    chk_pins();
    rdchk(1'b1, 8'h00);
    for (int i = 1; i < 4; i++) begin
      rdchk(1'b0, 8'(i));
    end
  endtask : chk_defaults

  task automatic alert_is(input logic exp);
    repeat (8) @(posedge core_clk);
    #1;
    chk1("alert_n", exp, i_ioxp_if.alert_n);
  endtask : alert_is

  initial begin : main
    logic [7:0] r;
    void'($urandom(32'ha3cb));
    do_reset();
    chk_defaults();
    $display("test reset_defaults done");
    stall_on = 1'b1;
    for (int i = 0; i < 20; i++) begin
      r = 8'($urandom);
      if (i < 4) begin
        r = {r[7:2], 2'(i)};
      end
      ext = 8'($urandom);
      addr_sel = (i >= 10);
      wr(r, 8'($urandom));
      chk_pins();
      rdchk(1'b1, 8'h00);
      rdchk(1'b0, 8'($urandom));
    end
    stall_on = 1'b0;
    $display("test random_access done");
    xfer(1'b0, 1'b0, 7'h20, 8'h01, ~m_out);
    chk1("foreign write nack", 1'b1, nk);
    xfer(1'b1, 1'b1, 7'h22, 8'h00, 8'h00);
    chk1("foreign read nack", 1'b1, nk);
    rdchk(1'b0, 8'h01);
    $display("test foreign_address done");
    wr(8'h03, 8'hff);
    rdchk(1'b0, 8'h00);
    alert_is(1'b1);
    ext = ext ^ 8'h10;
    alert_is(1'b0);
    ext = ext ^ 8'h10;
    alert_is(1'b1);
    ext = ext ^ 8'h01;
    alert_is(1'b0);
    rdchk(1'b1, 8'h00);
    alert_is(1'b1);
    wr(8'h03, 8'h00);
    ext = ~ext;
    alert_is(1'b1);
    $display("test alert done");
    do_reset();
    chk_defaults();
    $display("test mid_reset done");
    finish_test();
  end

  initial begin : watchdog
    #450000;
    err_count++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end
endmodule : testbench
